// file: design/dsa_pkg.sv
// Constants and types for the accumulator and control-access datapath
package dsa_pkg;

	// Register offsets on the APB bus
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_OPCOUNT = 12'h004;

	// Control register field layout
	localparam int POS_LSB = 0;
	localparam int POS_W = 6;
	localparam logic [31:0] FLD_POS = 32'h0000_003f;
	localparam logic [31:0] FLD_SCOUNT = 32'h0000_1f80;
	localparam logic [31:0] FLD_CARRY = 32'h0000_2000;
	localparam logic [31:0] FLD_EFI = 32'h0000_4000;
	localparam logic [31:0] FLD_OUFLAG = 32'h00ff_0000;
	localparam logic [31:0] FLD_CCOND = 32'hff00_0000;
	localparam int EFI_BIT = 14;

	// Mask bit index to control field
	localparam int MBIT_POS = 0;
	localparam int MBIT_SCOUNT = 1;
	localparam int MBIT_CARRY = 2;
	localparam int MBIT_OUFLAG = 3;
	localparam int MBIT_CCOND = 4;
	localparam int MBIT_EFI = 5;

	// Reset values and constants
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] ACC_RST = 32'h0000_0000;
	localparam logic [31:0] Q31_MAX = 32'h7fff_ffff;
	localparam logic [5:0] POS_WORD_STEP = 6'h20;
	localparam int NUM_ACC = 4;

	// Operations issued by the core pipeline
	typedef enum logic [4:0] {
		OP_EXTRACT_WORD = 5'b00000,
		OP_EXTRACT_WORD_ROUND = 5'b00001,
		OP_EXTRACT_WORD_ROUND_SAT = 5'b00010,
		OP_EXTRACT_WORD_VAR_SHIFT = 5'b00011,
		OP_EXTRACT_WORD_VAR_ROUND = 5'b00100,
		OP_EXTRACT_WORD_VAR_ROUND_SAT = 5'b00101,
		OP_BITFIELD_EXTRACT = 5'b00110,
		OP_BITFIELD_EXTRACT_VAR = 5'b00111,
		OP_BITFIELD_EXTRACT_DECREMENT = 5'b01000,
		OP_BITFIELD_EXTRACT_DECREMENT_VAR = 5'b01001,
		OP_ACCUM_SHIFT = 5'b01010,
		OP_ACCUM_SHIFT_VAR = 5'b01011,
		OP_ACCUM_SHIFT_IN_WORD = 5'b01100,
		OP_READ_UPPER_HALF = 5'b01101,
		OP_READ_BOTTOM_HALF = 5'b01110,
		OP_WRITE_UPPER_HALF = 5'b01111,
		OP_WRITE_BOTTOM_HALF = 5'b10000,
		OP_WRITE_CTRL_FIELDS = 5'b10001,
		OP_READ_CTRL_FIELDS = 5'b10010
	} dsa_op_t;

endpackage

// file: design/dsa_top.sv
// Accumulator and control-access datapath with APB access to the control register
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module dsa_top (
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	// Operation request from the core pipeline
	input wire logic OP_VALID_I,
	input wire logic [4:0] OP_CODE_I,
	input wire logic [1:0] OP_SUM_REGISTER_SELECT_I,
	input wire logic [63:0] OP_SOURCE_OPERAND_I,
	input wire logic [63:0] OP_TARGET_GENERAL_I,
	input wire logic [5:0] OP_IMM_I,
	// Result to the general register file
	output logic RES_VALID_O,
	output logic [63:0] RES_DATA_O,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O
);

	////////////////////////////////////////////////////////////////////////
	// Functions

	function automatic logic [63:0] sext32(input logic [31:0] w);
		sext32 = {{32{w[31]}}, w};
	endfunction

	function automatic logic [31:0] field_mask(input logic [5:0] m);
		field_mask = 32'h0;
		if (m[dsa_pkg::MBIT_POS]) field_mask = field_mask | dsa_pkg::FLD_POS;
		if (m[dsa_pkg::MBIT_SCOUNT]) field_mask = field_mask | dsa_pkg::FLD_SCOUNT;
		if (m[dsa_pkg::MBIT_CARRY]) field_mask = field_mask | dsa_pkg::FLD_CARRY;
		if (m[dsa_pkg::MBIT_OUFLAG]) field_mask = field_mask | dsa_pkg::FLD_OUFLAG;
		if (m[dsa_pkg::MBIT_CCOND]) field_mask = field_mask | dsa_pkg::FLD_CCOND;
		if (m[dsa_pkg::MBIT_EFI]) field_mask = field_mask | dsa_pkg::FLD_EFI;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	logic [31:0] hi_q [dsa_pkg::NUM_ACC];
	logic [31:0] lo_q [dsa_pkg::NUM_ACC];
	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic [31:0] opcount_q;
	logic res_valid_q;
	logic [63:0] res_data_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	////////////////////////////////////////////////////////////////////////
	// Operation decode

	wire dsa_pkg::dsa_op_t op = dsa_pkg::dsa_op_t'(OP_CODE_I);
	wire [1:0] sel = OP_SUM_REGISTER_SELECT_I;
	wire [63:0] src = OP_SOURCE_OPERAND_I;
	wire [63:0] tgt = OP_TARGET_GENERAL_I;
	wire is_xw_var = op inside {dsa_pkg::OP_EXTRACT_WORD_VAR_SHIFT,
		dsa_pkg::OP_EXTRACT_WORD_VAR_ROUND, dsa_pkg::OP_EXTRACT_WORD_VAR_ROUND_SAT};
	wire is_xw = is_xw_var || op inside {dsa_pkg::OP_EXTRACT_WORD,
		dsa_pkg::OP_EXTRACT_WORD_ROUND, dsa_pkg::OP_EXTRACT_WORD_ROUND_SAT};
	wire is_xw_rnd = op inside {dsa_pkg::OP_EXTRACT_WORD_ROUND,
		dsa_pkg::OP_EXTRACT_WORD_ROUND_SAT, dsa_pkg::OP_EXTRACT_WORD_VAR_ROUND,
		dsa_pkg::OP_EXTRACT_WORD_VAR_ROUND_SAT};
	wire is_xw_sat = op inside {dsa_pkg::OP_EXTRACT_WORD_ROUND_SAT,
		dsa_pkg::OP_EXTRACT_WORD_VAR_ROUND_SAT};
	wire is_bf_var = op inside {dsa_pkg::OP_BITFIELD_EXTRACT_VAR,
		dsa_pkg::OP_BITFIELD_EXTRACT_DECREMENT_VAR};
	wire is_bf_dec = op inside {dsa_pkg::OP_BITFIELD_EXTRACT_DECREMENT,
		dsa_pkg::OP_BITFIELD_EXTRACT_DECREMENT_VAR};
	wire is_bf = is_bf_var || is_bf_dec || op == dsa_pkg::OP_BITFIELD_EXTRACT;
	wire is_sh = op inside {dsa_pkg::OP_ACCUM_SHIFT, dsa_pkg::OP_ACCUM_SHIFT_VAR};
	wire is_siw = op == dsa_pkg::OP_ACCUM_SHIFT_IN_WORD;
	wire is_wctl = op == dsa_pkg::OP_WRITE_CTRL_FIELDS;
	wire is_rctl = op == dsa_pkg::OP_READ_CTRL_FIELDS;
	wire is_rhi = op == dsa_pkg::OP_READ_UPPER_HALF;
	wire is_rlo = op == dsa_pkg::OP_READ_BOTTOM_HALF;
	wire is_whi = op == dsa_pkg::OP_WRITE_UPPER_HALF;
	wire is_wlo = op == dsa_pkg::OP_WRITE_BOTTOM_HALF;
	wire gpr_op = is_xw || is_bf || is_rctl || is_rhi || is_rlo;
	wire known_op = gpr_op || is_sh || is_siw || is_wctl || is_whi || is_wlo;
	wire go = OP_VALID_I && known_op;

	// 64-bit accumulator view; upper and lower halves concatenated
	wire [31:0] acc_hi = hi_q[sel];
	wire [31:0] acc_lo = lo_q[sel];
	wire [63:0] acc = {acc_hi, acc_lo};
	wire [5:0] pos = ctrl_q[dsa_pkg::POS_LSB +: dsa_pkg::POS_W];

	////////////////////////////////////////////////////////////////////////
	// Word extract

	wire [4:0] xw_sh = is_xw_var ? src[4:0] : OP_IMM_I[4:0];
	wire [63:0] xw_trunc = acc >> xw_sh;
	wire [64:0] xw_half = (xw_sh == 5'h0) ? 65'h0 : (65'h1 << (xw_sh - 5'h1));
	wire [64:0] xw_sum = {1'b0, acc} + xw_half;
	wire [64:0] xw_rnd = xw_sum >> xw_sh;
	wire xw_ovf = !xw_trunc[31] && xw_rnd[31];
	wire [31:0] xw_word = (is_xw_sat && xw_ovf) ? dsa_pkg::Q31_MAX :
		(is_xw_rnd ? xw_rnd[31:0] : xw_trunc[31:0]);

	////////////////////////////////////////////////////////////////////////
	// Bit-field extract

	wire [4:0] bf_size = is_bf_var ? src[4:0] : OP_IMM_I[4:0];
	wire [5:0] bf_start = pos - {1'b0, bf_size};
	wire [5:0] bf_up = 6'h3f - {1'b0, bf_size};
	wire [63:0] bf_raw = acc >> bf_start;
	wire [63:0] bf_left = bf_raw << bf_up;
	wire [63:0] bf_res = $signed(bf_left) >>> bf_up;
	wire bf_oor = pos < {1'b0, bf_size};
	wire [5:0] bf_pos_dec = pos - {1'b0, bf_size} - 6'h01;

	////////////////////////////////////////////////////////////////////////
	// Accumulator shift

	wire [5:0] sh_amt = (op == dsa_pkg::OP_ACCUM_SHIFT_VAR) ? src[5:0] : OP_IMM_I;
	wire [5:0] sh_mag = 6'h00 - sh_amt;
	wire [63:0] sh_res = sh_amt[5] ? (acc >> sh_mag) : (acc << sh_amt[4:0]);

	////////////////////////////////////////////////////////////////////////
	// Control-field access

	wire [31:0] fmask = field_mask(OP_IMM_I);
	wire [31:0] ctrl_wr = (ctrl_q & ~fmask) | (tgt[31:0] & fmask);
	wire [63:0] rctl_res = {tgt[63:32], (tgt[31:0] & ~fmask) | (ctrl_q & fmask)};

	wire [63:0] res_d = is_xw ? sext32(xw_word) :
		is_bf ? bf_res :
		is_rctl ? rctl_res :
		is_rhi ? sext32(acc_hi) : sext32(acc_lo);

	////////////////////////////////////////////////////////////////////////
	// APB decode

	wire apb_acc = PSEL_I && PENABLE_I && !pready_q;
	wire hit_ctrl = PADDR_I == dsa_pkg::ADDR_CTRL;
	wire hit_cnt = PADDR_I == dsa_pkg::ADDR_OPCOUNT;
	// Bus write lands at the edge that completes the access
	wire apb_wctl = PSEL_I && PENABLE_I && pready_q && PWRITE_I && hit_ctrl;
	wire [31:0] rd_d = hit_ctrl ? ctrl_q : (hit_cnt ? opcount_q : 32'h0);
	wire [31:0] ctrl_all = dsa_pkg::FLD_POS | dsa_pkg::FLD_SCOUNT | dsa_pkg::FLD_CARRY
		| dsa_pkg::FLD_EFI | dsa_pkg::FLD_OUFLAG | dsa_pkg::FLD_CCOND;

	// Control next value; core operation wins over a bus write
	always_comb begin
		ctrl_d = ctrl_q;
		if (go && is_wctl) begin
			ctrl_d = ctrl_wr & ctrl_all;
		end else if (go && is_bf) begin
			ctrl_d[dsa_pkg::EFI_BIT] = bf_oor;
			if (is_bf_dec) begin
				ctrl_d[dsa_pkg::POS_LSB +: dsa_pkg::POS_W] = bf_pos_dec;
			end
		end else if (go && is_siw) begin
			ctrl_d[dsa_pkg::POS_LSB +: dsa_pkg::POS_W] = pos + dsa_pkg::POS_WORD_STEP;
		end else if (apb_wctl) begin
			ctrl_d = PWDATA_I & ctrl_all;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			for (int i = 0; i < dsa_pkg::NUM_ACC; i++) begin
				hi_q[i] <= dsa_pkg::ACC_RST;
				lo_q[i] <= dsa_pkg::ACC_RST;
			end
		end else if (go && is_sh) begin
			hi_q[sel] <= sh_res[63:32];
			lo_q[sel] <= sh_res[31:0];
		end else if (go && is_siw) begin
			hi_q[sel] <= acc_lo;
			lo_q[sel] <= src[31:0];
		end else if (go && is_whi) begin
			hi_q[sel] <= src[31:0];
		end else if (go && is_wlo) begin
			lo_q[sel] <= src[31:0];
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ctrl_q <= dsa_pkg::CTRL_RST;
			opcount_q <= 32'h0;
			res_valid_q <= 1'b0;
			res_data_q <= 64'h0;
		end else begin
			ctrl_q <= ctrl_d;
			opcount_q <= opcount_q + {31'h0, go};
			res_valid_q <= go && gpr_op;
			res_data_q <= (go && gpr_op) ? res_d : res_data_q;
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= apb_acc;
			prdata_q <= (apb_acc && !PWRITE_I) ? rd_d : 32'h0;
			pslverr_q <= apb_acc && !hit_ctrl && !hit_cnt;
		end
	end

	assign RES_VALID_O = res_valid_q;
	assign RES_DATA_O = res_data_q;
	assign PRDATA_O = prdata_q;
	assign PREADY_O = pready_q;
	assign PSLVERR_O = pslverr_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);

	result_latency_a: assert property (go && gpr_op |=> RES_VALID_O)
		else $error("result not valid one cycle after request");
	trunc_word_a: assert property (go && is_xw && !is_xw_rnd |=>
		RES_DATA_O == sext32($past(xw_trunc[31:0])))
		else $error("truncated extract wrong");
	sat_clamp_a: assert property (go && is_xw_sat && xw_ovf |=>
		RES_DATA_O == 64'h0000_0000_7fff_ffff)
		else $error("saturated extract not clamped");
	round_word_a: assert property (go && is_xw_rnd && !is_xw_sat && xw_sh == 5'h0 |=>
		RES_DATA_O == sext32($past(acc_lo)))
		else $error("zero shift rounding changed value");
	bf_pos_dec_a: assert property (go && is_bf_dec && !is_wctl |=>
		ctrl_q[5:0] == $past(pos) - $past({1'b0, bf_size}) - 6'h01)
		else $error("pointer not lowered by field width");
	siw_pos_a: assert property (go && is_siw |=> ctrl_q[5:0] == $past(pos) + 6'h20)
		else $error("pointer not raised by 32");
	siw_move_a: assert property (go && is_siw |=>
		hi_q[$past(sel)] == $past(acc_lo) && lo_q[$past(sel)] == $past(src[31:0]))
		else $error("shift-in-word halves wrong");
	ctrl_keep_a: assert property (go && is_wctl |=>
		(ctrl_q & ~$past(fmask)) == ($past(ctrl_q) & ~$past(fmask)))
		else $error("unmasked control field changed");
	ctrl_read_a: assert property (go && is_rctl |=>
		RES_DATA_O[63:32] == $past(tgt[63:32]) && (RES_DATA_O[31:0] & ~$past(fmask))
		== ($past(tgt[31:0]) & ~$past(fmask)))
		else $error("unmasked target bits changed");
	bf_sign_a: assert property (go && is_bf && bf_size == 5'h0 |=>
		RES_DATA_O == {64{$past(acc[pos])}})
		else $error("single-bit field not sign-extended");
	shift_left_a: assert property (go && is_sh && !sh_amt[5] |=>
		{hi_q[$past(sel)], lo_q[$past(sel)]} == ($past(acc) << $past(sh_amt[4:0])))
		else $error("left accumulator shift wrong");
	apb_ready_a: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
		else $error("bus access not answered");
	shift_right_a: assert property (go && is_sh && sh_amt[5] |=>
		{hi_q[$past(sel)], lo_q[$past(sel)]} == ($past(acc) >> (7'h40 - {1'b0, $past(sh_amt)})))
		else $error("right accumulator shift wrong");
	half_write_a: assert property (go && is_wlo |=>
		lo_q[$past(sel)] == $past(src[31:0]))
		else $error("bottom half not written");
	efi_flag_a: assert property (go && is_bf |=>
		ctrl_q[dsa_pkg::EFI_BIT] == ($past(pos) < $past({1'b0, bf_size})))
		else $error("out-of-range flag wrong");
	apb_write_a: assert property (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !OP_VALID_I &&
		PADDR_I == dsa_pkg::ADDR_CTRL |=> ctrl_q == ($past(PWDATA_I) & ctrl_all))
		else $error("bus write to control not applied");

	trunc_cov: cover property (go && op == dsa_pkg::OP_EXTRACT_WORD_VAR_SHIFT);
	sat_cov: cover property (go && is_xw_sat && xw_ovf);
	bf_dec_cov: cover property (go && is_bf_dec ##1 go && is_bf_dec);
	siw_cov: cover property (go && is_siw);
	shr_cov: cover property (go && is_sh && sh_amt == 6'h20);

endmodule // dsa_top

`default_nettype wire

// file: testbench/dsa_core_model.sv
// Core pipeline model issuing operations and collecting results
`timescale 1ns/100ps
`default_nettype none
module dsa_core_model (
	// Clock
	input wire logic clk_i,
	// Result from the datapath
	input wire logic res_valid_i,
	input wire logic [63:0] res_data_i,
	// Operation to the datapath
	output logic op_valid_o,
	output logic [4:0] op_code_o,
	output logic [1:0] op_sel_o,
	output logic [63:0] op_src_o,
	output logic [63:0] op_tgt_o,
	output logic [5:0] op_imm_o
);
	initial begin
		op_valid_o = 1'b0;
		op_code_o = 5'h1f;
		op_sel_o = 2'h0;
		op_src_o = 64'h0;
		op_tgt_o = 64'h0;
		op_imm_o = 6'h0;
	end
	////////////////////////////////////////////////////////////////
	// Called at an edge; keep leaves valid up for a back-to-back op
	task automatic issue(input logic [4:0] c, input logic [1:0] s, input logic [63:0] a,
		input logic [63:0] b, input logic [5:0] m, input bit keep,
		output logic v, output logic [63:0] d);
		op_valid_o <= 1'b1;
		op_code_o <= c;
		op_sel_o <= s;
		op_src_o <= a;
		op_tgt_o <= b;
		op_imm_o <= m;
		@(posedge clk_i);
		v = 1'b0;
		d = 64'h0;
		if (!keep) begin
			// Stale operands once the op is taken
			op_valid_o <= 1'b0;
			op_src_o <= ~a;
			op_tgt_o <= ~b;
			op_imm_o <= ~m;
			@(posedge clk_i);
			v = res_valid_i;
			d = res_data_i;
		end
	endtask
endmodule // dsa_core_model
`default_nettype wire

// file: testbench/tb_dsp_accumulator_access.sv
// Self-checking bench for the accumulator and control-access datapath
`timescale 1ns/100ps
`default_nettype none
module tb_dsp_accumulator_access;
	typedef struct packed {
		dsa_pkg::dsa_op_t op;
		logic [1:0] chk;
		logic [5:0] imm;
		logic [31:0] src;
		logic [63:0] acc;
		logic [31:0] ctl;
		logic [31:0] ectl;
		logic [63:0] exp;
	} dsa_row_t;
	logic clk, rst, op_valid, res_valid, v, er;
	logic psel, penable, pwrite, pready, pslverr;
	logic [4:0] op_code;
	logic [1:0] op_sel, sel;
	logic [5:0] op_imm;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [63:0] op_src, op_tgt, res_data, d;
	int error_cnt, n_compared, n_ops, cyc;
	dsa_row_t rows[19] = '{
		'{dsa_pkg::OP_EXTRACT_WORD,0,6'h04,0,64'h12345678f,0,0,64'h12345678},
		'{dsa_pkg::OP_EXTRACT_WORD_VAR_SHIFT,0,6'h3f,32'hffffffe4,64'hf00000000,0,0,
			64'hfffffffff0000000},
		'{dsa_pkg::OP_EXTRACT_WORD_ROUND,0,6'h04,0,64'h18,0,0,64'h2},
		'{dsa_pkg::OP_EXTRACT_WORD_ROUND_SAT,0,6'h01,0,64'hffffffff,0,0,64'h7fffffff},
		'{dsa_pkg::OP_EXTRACT_WORD_ROUND,0,6'h01,0,64'hffffffff,0,0,64'hffffffff80000000},
		'{dsa_pkg::OP_EXTRACT_WORD_VAR_ROUND,0,6'h00,32'hffffffe1,64'h3,0,0,64'h2},
		'{dsa_pkg::OP_EXTRACT_WORD_VAR_ROUND_SAT,0,6'h00,32'hffffffe1,64'hffffffff,0,0,
			64'h7fffffff},
		'{dsa_pkg::OP_EXTRACT_WORD,0,6'h1f,0,64'hffffffff00000000,0,0,
			64'hfffffffffffffffe},
		'{dsa_pkg::OP_BITFIELD_EXTRACT,0,6'h07,0,64'h5b00,32'hf,32'hf,64'h5b},
		'{dsa_pkg::OP_BITFIELD_EXTRACT_VAR,0,6'h00,32'hffffffe3,64'h700000000,32'h23,32'h23,
			64'h7},
		'{dsa_pkg::OP_BITFIELD_EXTRACT_DECREMENT,0,6'h07,0,64'h5b00,32'hf,32'h7,64'h5b},
		'{dsa_pkg::OP_BITFIELD_EXTRACT_DECREMENT_VAR,0,6'h00,32'hffffffe3,64'h700000000,
			32'h23,32'h1f,64'h7},
		'{dsa_pkg::OP_ACCUM_SHIFT,1,6'h04,0,64'h12345678f,0,0,64'h12},
		'{dsa_pkg::OP_ACCUM_SHIFT,2,6'h3c,0,64'h12345678f,0,0,64'h12345678},
		'{dsa_pkg::OP_ACCUM_SHIFT_VAR,2,6'h04,32'hffffffe0,64'h8000000000000000,0,0,
			64'hffffffff80000000},
		'{dsa_pkg::OP_ACCUM_SHIFT_IN_WORD,1,6'h00,32'h42,64'h100000055,32'h28,32'h8,
			64'h55},
		'{dsa_pkg::OP_WRITE_CTRL_FIELDS,1,6'h1e,32'hffffffff,0,32'h5,32'hffff3f85,0},
		'{dsa_pkg::OP_WRITE_CTRL_FIELDS,1,6'h21,32'h4021,0,32'hff000000,32'hff004021,0},
		'{dsa_pkg::OP_READ_CTRL_FIELDS,0,6'h01,32'haaaaaaaa,0,32'h12342a07,32'h12342a07,
			64'haaaaaaaaaaaaaa87}
	};
	////////////////////////////////////////////////////////////////
	dsa_top u_dut (.REF_CLK_I(clk), .RST_I(rst), .OP_VALID_I(op_valid), .OP_CODE_I(op_code),
		.OP_SUM_REGISTER_SELECT_I(op_sel), .OP_SOURCE_OPERAND_I(op_src),
		.OP_TARGET_GENERAL_I(op_tgt), .OP_IMM_I(op_imm), .RES_VALID_O(res_valid),
		.RES_DATA_O(res_data), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr));
	dsa_core_model u_core (.clk_i(clk), .res_valid_i(res_valid), .res_data_i(res_data),
		.op_valid_o(op_valid), .op_code_o(op_code), .op_sel_o(op_sel), .op_src_o(op_src),
		.op_tgt_o(op_tgt), .op_imm_o(op_imm));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= w;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic op(input logic [4:0] c, input logic [5:0] m, input logic [31:0] s, input bit k);
		u_core.issue(c, sel, {32'hffffffff, s}, {s, s}, m, k, v, d);
		if (c <= dsa_pkg::OP_READ_CTRL_FIELDS)
			n_ops++;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			print_verdict();
		end
	end
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, sel} = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check(res_valid, 1'b0);
		apb(1'b0, dsa_pkg::ADDR_CTRL, 32'h0);
		check(rd, dsa_pkg::CTRL_RST);
		for (int i = 0; i < 19; i++) begin
			sel = 2'(i);
			apb(1'b1, dsa_pkg::ADDR_CTRL, rows[i].ctl);
			op(dsa_pkg::OP_WRITE_UPPER_HALF, 6'h0, rows[i].acc[63:32], 1'b0);
			op(dsa_pkg::OP_WRITE_BOTTOM_HALF, 6'h0, rows[i].acc[31:0], 1'b0);
			op(rows[i].op, rows[i].imm, rows[i].src, 1'b0);
			if (rows[i].chk != 2'h0) begin
				check(v, 1'b0);
				op(rows[i].chk == 2'h1 ? dsa_pkg::OP_READ_UPPER_HALF : dsa_pkg::OP_READ_BOTTOM_HALF,
					6'h0, 32'h0, 1'b0);
			end
			check(v, 1'b1);
			check(d, rows[i].exp);
			apb(1'b0, dsa_pkg::ADDR_CTRL, 32'h0);
			check(rd, rows[i].ectl);
		end
		// Back-to-back half write then read
		op(dsa_pkg::OP_WRITE_BOTTOM_HALF, 6'h0, 32'habcd, 1'b1);
		op(dsa_pkg::OP_READ_BOTTOM_HALF, 6'h0, 32'h0, 1'b0);
		check(d, 64'habcd);
		// Pointer wraps below zero
		apb(1'b1, dsa_pkg::ADDR_CTRL, 32'h3);
		op(dsa_pkg::OP_BITFIELD_EXTRACT_DECREMENT, 6'h07, 32'h0, 1'b0);
		apb(1'b0, dsa_pkg::ADDR_CTRL, 32'h0);
		check(rd, 32'h403b);
		apb(1'b1, dsa_pkg::ADDR_CTRL, 32'hffffffff);
		apb(1'b0, dsa_pkg::ADDR_CTRL, 32'h0);
		check(rd, 32'hffff7fbf);
		check(er, 1'b0);
		op(dsa_pkg::dsa_op_t'(5'h1f), 6'h0, 32'h0, 1'b0);
		check(v, 1'b0);
		apb(1'b1, dsa_pkg::ADDR_OPCOUNT, 32'hffff);
		check(er, 1'b0);
		apb(1'b0, dsa_pkg::ADDR_OPCOUNT, 32'h0);
		check(rd, n_ops);
		apb(1'b0, 12'h008, 32'h0);
		check(er, 1'b1);
		check(rd, 32'h0);
		// Mid-run reset clears accumulators, control and count
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check(res_valid, 1'b0);
		apb(1'b0, dsa_pkg::ADDR_CTRL, 32'h0);
		check(rd, dsa_pkg::CTRL_RST);
		apb(1'b0, dsa_pkg::ADDR_OPCOUNT, 32'h0);
		check(rd, 32'h0);
		op(dsa_pkg::OP_READ_BOTTOM_HALF, 6'h0, 32'h0, 1'b0);
		check(d, 64'(dsa_pkg::ACC_RST));
		print_verdict();
	end
endmodule // tb_dsp_accumulator_access
`default_nettype wire
